//--- hw/io_channel_pkg.sv
// Purpose: shared constants and types of the i/o channel unit
// Assumes: one 125 MHz clock, 24-bit words, 12-bit core addresses
// Notes:   descriptor fields apply to drum transfer words
`default_nettype none
package io_channel_pkg;
	localparam int WORD_W      = 24;           // data, mask and line group width
	localparam int ADDR_W      = 12;           // core memory address width
	localparam int GROUPS      = 8;            // sense / select line groups
	localparam int BUFS        = 8;            // i/o buffer registers
	localparam int SEL_W       = 3;            // group / register number width
	localparam int PRIO_LINES  = 8;            // priority request inputs
	localparam int RANK_W      = 3;            // priority value 1-8 held as 0-7
	localparam int TRACK_DEPTH = 8;            // words per buffer track fifo
	localparam int DESC_ADDR_LSB = 0;          // first core word of a drum transfer
	localparam int DESC_CNT_LSB  = 12;         // word count of a drum transfer
	localparam int DESC_CNT_W    = 12;
	localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

	typedef enum logic [2:0] {
		OP_SENSE,      // sense_group_op
		OP_SETUP,      // device_setup_op
		OP_LOAD,       // buffer_load_op
		OP_STORE,      // buffer_store_op
		OP_DRUM_WRITE, // drum_write_op
		OP_DRUM_READ   // drum_read_op
	} io_op_t;
endpackage
`default_nettype wire

//--- hw/stream_if.sv
// Purpose: valid/ready word stream between the unit and its track fifos
// Assumes: single clock domain
// Notes:   a word moves on a cycle where valid and ready are both high
`default_nettype none
interface stream_if #(parameter int W = 24);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- hw/track_fifo.sv
// Purpose: buffer track storage, a parameterised synchronous fifo
// Assumes: filler and drainer on mclk
// Notes:   full drops ready upstream; empty drops valid downstream
`default_nettype none
module track_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 8
) (
	input  wire logic mclk,
	input  wire logic nrst,
	stream_if.snk     fill,
	stream_if.src     drain
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0]  store_ff [DEPTH];
	logic [PW-1:0] wptr_ff;
	logic [PW-1:0] rptr_ff;
	logic [PW:0]   count_ff;
	logic          push;
	logic          pop;

	// handshake and occupancy
	assign fill.ready  = (count_ff != (PW+1)'(DEPTH));
	assign drain.valid = (count_ff != '0);
	assign drain.data  = store_ff[rptr_ff];
	assign push        = fill.valid & fill.ready;
	assign pop         = drain.valid & drain.ready;

	// storage words
	always_ff @(posedge mclk) begin
		if (push) begin
			store_ff[wptr_ff] <= fill.data;
		end
	end

	// pointers and count
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wptr_ff  <= '0;
			rptr_ff  <= '0;
			count_ff <= '0;
		end else begin
			if (push) wptr_ff <= (wptr_ff == PW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
			if (pop) rptr_ff <= (rptr_ff == PW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
			count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// occupancy bound
	fifo_bound_a: assert property (count_ff <= (PW+1)'(DEPTH))
		else $error("track fifo over capacity");
endmodule // track_fifo
`default_nettype wire

//--- hw/io_channel_unit.sv
// Purpose: i/o channels - sense, select, buffer registers, priority, drum tracks
// Assumes: sequencer issues one op at a time; peripheral data ports on mclk
// Notes:   status and priority pins are asynchronous and pass a 3-flop filter
// Functional notes
// - 192 status sense inputs in eight groups of 24; sense picks one group.
// - sense ANDs chosen group with mask word from memory into left accumulator.
// - 192 select outputs in eight groups; setup activates chosen lines in one group.
// - eight independently addressed 24-bit buffer registers numbered 0 to 7.
// - register 0 serves standard peripherals, others serve special devices.
// - load moves memory word into register; store moves register into memory.
// - load stalls while target register still holds an untaken word.
// - store stalls until the input device has filled the target register.
// - eight priority request inputs into request register, each ranked 1 to 8.
// - drum track transfers run beside instruction execution; it waits only behind an engine access in flight or, for a drum op, a busy engine.
// - read tracks filled by device, emptied to memory by drum read.
// - write tracks filled by drum write, then unloaded to device.
// - each buffer track has its own fifo and device handshake; one engine serves one track at a time.
// - every operand address except a store's points to a parameter word; a store writes its data word there.
`default_nettype none
module io_channel_unit
	import io_channel_pkg::*;
(
	input  wire logic                           mclk,
	input  wire logic                           nrst,
	// sequencer command port
	input  wire logic                           cmd_valid,
	output logic                                cmd_ready,
	input  wire io_op_t                         cmd_op,
	input  wire logic [SEL_W-1:0]               cmd_sel,
	input  wire logic [ADDR_W-1:0]              cmd_addr,
	output logic                                op_done,
	output logic                                lacc_we,
	output logic [WORD_W-1:0]                   lacc_data,
	// core memory port
	output logic                                mem_req,
	output logic                                mem_we,
	output logic [ADDR_W-1:0]                   mem_addr,
	output logic [WORD_W-1:0]                   mem_wdata,
	input  wire logic                           mem_gnt,
	input  wire logic [WORD_W-1:0]              mem_rdata,
	// line groups
	input  wire logic [GROUPS-1:0][WORD_W-1:0]  status_sense_lines,
	output logic      [GROUPS-1:0][WORD_W-1:0]  device_select_lines,
	// buffer registers, peripheral side
	input  wire logic [BUFS-1:0]                buf_fill_we,
	input  wire logic [WORD_W-1:0]              buf_fill_data,
	input  wire logic [BUFS-1:0]                buf_take,
	output logic      [BUFS-1:0]                buf_full,
	output logic      [BUFS-1:0][WORD_W-1:0]    io_buffer_register,
	// priority requests
	input  wire logic [PRIO_LINES-1:0]          prio_req_pin,
	input  wire logic [PRIO_LINES-1:0][RANK_W-1:0] prio_rank,
	input  wire logic [PRIO_LINES-1:0]          prio_service,
	output logic      [PRIO_LINES-1:0]          priority_request_reg,
	output logic                                prio_top_valid,
	output logic      [SEL_W-1:0]               prio_top_line,
	// drum buffer tracks, device side
	input  wire logic                           rd_track_valid,
	output logic                                rd_track_ready,
	input  wire logic [WORD_W-1:0]              rd_track_data,
	output logic                                wr_track_valid,
	input  wire logic                           wr_track_ready,
	output logic [WORD_W-1:0]                   wr_track_data,
	output logic                                drum_busy
);
	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	localparam int SYN_W = GROUPS*WORD_W + PRIO_LINES;
	logic [SYN_W-1:0] syn1_ff, syn2_ff, syn3_ff, syn_ok_ff;
	logic [GROUPS-1:0][WORD_W-1:0] sense_now;
	logic [PRIO_LINES-1:0]         prio_now;

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			syn1_ff   <= '0;
			syn2_ff   <= '0;
			syn3_ff   <= '0;
			syn_ok_ff <= '0;
		end else begin
			syn1_ff   <= {status_sense_lines, prio_req_pin};
			syn2_ff   <= syn1_ff;
			syn3_ff   <= syn2_ff;
			syn_ok_ff <= (syn3_ff & ~(syn2_ff ^ syn3_ff)) | (syn_ok_ff & (syn2_ff ^ syn3_ff));
		end
	end
	assign {sense_now, prio_now} = syn_ok_ff;

	// ------------------------------------------------------------------
	// priority request register
	// ------------------------------------------------------------------
	// lowest rank value wins; ties go to the lower line number
	function automatic logic [SEL_W:0] best_line(input logic [PRIO_LINES-1:0] pend,
		input logic [PRIO_LINES-1:0][RANK_W-1:0] rank);
		logic [SEL_W:0]  pick;
		logic [RANK_W:0] lvl;
		pick = '0;
		lvl  = {1'b1, {RANK_W{1'b0}}};
		for (int i = 0; i < PRIO_LINES; i++) begin
			if (pend[i] && ({1'b0, rank[i]} < lvl)) begin
				lvl  = {1'b0, rank[i]};
				pick = {1'b1, SEL_W'(i)};
			end
		end
		return pick;
	endfunction

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			priority_request_reg <= '0;
		end else begin
			priority_request_reg <= (priority_request_reg & ~prio_service) | prio_now;
		end
	end
	assign {prio_top_valid, prio_top_line} = best_line(priority_request_reg, prio_rank);

	// ------------------------------------------------------------------
	// instruction sequencing
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WAIT, S_PUT, S_DONE} seq_t;
	seq_t              state_ff;
	io_op_t            op_ff;
	logic [SEL_W-1:0]  sel_ff;
	logic [ADDR_W-1:0] yaddr_ff;
	logic [WORD_W-1:0] param_ff;
	logic              ins_want, eng_want, grab, own_ins_ff, busy_ff;
	logic              eng_act_ff, eng_dir_rd_ff;
	logic [ADDR_W-1:0] eng_addr_ff;
	logic [DESC_CNT_W-1:0] eng_cnt_ff;
	logic              ins_gnt, eng_gnt, drum_op, eng_go;

	assign drum_op   = (cmd_op == OP_DRUM_WRITE) || (cmd_op == OP_DRUM_READ);
	// drum ops wait only for a free engine, never for the transfer
	assign cmd_ready = (state_ff == S_IDLE) && !(drum_op && eng_act_ff);
	assign ins_gnt   = mem_gnt && own_ins_ff && busy_ff;
	assign eng_gnt   = mem_gnt && !own_ins_ff && busy_ff;
	assign ins_want  = (state_ff == S_FETCH) || (state_ff == S_PUT);

	// sequencer state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= S_IDLE;
			op_ff    <= OP_SENSE;
			sel_ff   <= '0;
			yaddr_ff <= '0;
			param_ff <= WORD_RST;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (cmd_valid && cmd_ready) begin
						op_ff    <= cmd_op;
						sel_ff   <= cmd_sel;
						yaddr_ff <= cmd_addr;
						// store waits for the register first
						state_ff <= (cmd_op == OP_STORE) ? S_WAIT : S_FETCH;
					end
				end
				S_FETCH: begin
					// operand address names the parameter word
					if (ins_gnt) begin
						param_ff <= mem_rdata;
						state_ff <= (op_ff == OP_LOAD) ? S_WAIT : S_DONE;
					end
				end
				S_WAIT: begin
					// load stalls while full; store stalls while not full
					if ((op_ff == OP_LOAD) && !buf_full[sel_ff]) state_ff <= S_DONE;
					if ((op_ff == OP_STORE) && buf_full[sel_ff]) state_ff <= S_PUT;
				end
				S_PUT: begin
					if (ins_gnt) state_ff <= S_DONE;
				end
				S_DONE: state_ff <= S_IDLE;
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// completion, accumulator and select lines
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			op_done             <= 1'b0;
			lacc_we             <= 1'b0;
			lacc_data           <= WORD_RST;
			device_select_lines <= '0;
		end else begin
			op_done <= (state_ff == S_DONE);
			lacc_we <= (state_ff == S_DONE) && (op_ff == OP_SENSE);
			// whole group masked into left accumulator
			if ((state_ff == S_DONE) && (op_ff == OP_SENSE)) begin
				lacc_data <= sense_now[sel_ff] & param_ff;
			end
			// chosen lines of one group activated by the pattern word
			if ((state_ff == S_DONE) && (op_ff == OP_SETUP)) begin
				device_select_lines[sel_ff] <= param_ff;
			end
		end
	end

	// ------------------------------------------------------------------
	// buffer registers
	// ------------------------------------------------------------------
	// eight registers, each with its own fill flag; 0 serves standard units
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			io_buffer_register <= '0;
			buf_full           <= '0;
		end else begin
			for (int i = 0; i < BUFS; i++) begin
				if (buf_take[i]) buf_full[i] <= 1'b0;
				if (buf_fill_we[i]) begin
					io_buffer_register[i] <= buf_fill_data;
					buf_full[i]           <= 1'b1;
				end
			end
			// load moves fetched word in once the register is empty
			if ((state_ff == S_WAIT) && (op_ff == OP_LOAD) && !buf_full[sel_ff]) begin
				io_buffer_register[sel_ff] <= param_ff;
				buf_full[sel_ff]           <= 1'b1;
			end
			// store empties the register as its word goes to memory
			if ((state_ff == S_PUT) && ins_gnt && !buf_fill_we[sel_ff]) begin
				buf_full[sel_ff] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// drum track engine and memory arbitration
	// ------------------------------------------------------------------
	stream_if #(.W(WORD_W)) rd_in ();
	stream_if #(.W(WORD_W)) rd_out ();
	stream_if #(.W(WORD_W)) wr_in ();
	stream_if #(.W(WORD_W)) wr_out ();

	// read track: device fills, engine drains to memory
	track_fifo #(.W(WORD_W), .DEPTH(TRACK_DEPTH)) rd_track (
		.mclk  (mclk),
		.nrst  (nrst),
		.fill  (rd_in),
		.drain (rd_out)
	);
	// write track: engine fills from memory, device drains
	track_fifo #(.W(WORD_W), .DEPTH(TRACK_DEPTH)) wr_track (
		.mclk  (mclk),
		.nrst  (nrst),
		.fill  (wr_in),
		.drain (wr_out)
	);
	assign rd_in.valid    = rd_track_valid;
	assign rd_in.data     = rd_track_data;
	assign rd_track_ready = rd_in.ready;
	assign wr_track_valid = wr_out.valid;
	assign wr_track_data  = wr_out.data;
	assign wr_out.ready   = wr_track_ready;
	assign drum_busy      = eng_act_ff;

	assign eng_go   = (state_ff == S_DONE) && (op_ff == OP_DRUM_WRITE || op_ff == OP_DRUM_READ);
	// a track with no room or no data stalls only the engine
	assign eng_want = eng_act_ff && (eng_dir_rd_ff ? rd_out.valid : wr_in.ready);
	assign grab     = !busy_ff && (ins_want || eng_want);
	assign rd_out.ready = grab && !ins_want && eng_dir_rd_ff;
	assign wr_in.valid  = eng_gnt && !mem_we;
	assign wr_in.data   = mem_rdata;

	// engine descriptor walk
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			eng_act_ff    <= 1'b0;
			eng_dir_rd_ff <= 1'b0;
			eng_addr_ff   <= '0;
			eng_cnt_ff    <= '0;
		end else if (eng_go) begin
			eng_dir_rd_ff <= (op_ff == OP_DRUM_READ);
			eng_addr_ff   <= param_ff[DESC_ADDR_LSB +: ADDR_W];
			eng_cnt_ff    <= param_ff[DESC_CNT_LSB +: DESC_CNT_W];
			eng_act_ff    <= (param_ff[DESC_CNT_LSB +: DESC_CNT_W] != '0);
		end else if (grab && !ins_want) begin
			eng_addr_ff <= eng_addr_ff + 1'b1;
			eng_cnt_ff  <= eng_cnt_ff - 1'b1;
			eng_act_ff  <= (eng_cnt_ff != DESC_CNT_W'(1));
		end
	end

	// one memory access at a time; the sequencer goes first
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy_ff    <= 1'b0;
			own_ins_ff <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= '0;
			mem_wdata  <= WORD_RST;
		end else if (grab) begin
			busy_ff    <= 1'b1;
			own_ins_ff <= ins_want;
			mem_we     <= ins_want ? (state_ff == S_PUT) : eng_dir_rd_ff;
			mem_addr   <= ins_want ? yaddr_ff : eng_addr_ff;
			mem_wdata  <= ins_want ? io_buffer_register[sel_ff] : rd_out.data;
		end else if (mem_gnt) begin
			busy_ff <= 1'b0;
		end
	end
	assign mem_req = busy_ff;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sense_result_a: assert property (
		lacc_we |-> lacc_data == ($past(sense_now[sel_ff]) & $past(param_ff)))
		else $error("sense result not mask AND group");
	sense_pulse_a: assert property (
		lacc_we |-> op_done && $past(op_ff == OP_SENSE))
		else $error("accumulator written outside sense");
	setup_lines_a: assert property (
		(state_ff == S_DONE && op_ff == OP_SETUP) |=> device_select_lines[$past(sel_ff)] == $past(param_ff))
		else $error("select group not set from pattern");
	load_stall_a: assert property (
		(state_ff == S_WAIT && op_ff == OP_LOAD && buf_full[sel_ff]) |=> state_ff == S_WAIT)
		else $error("load passed a full register");
	store_stall_a: assert property (
		(state_ff == S_WAIT && op_ff == OP_STORE && !buf_full[sel_ff]) |=> state_ff != S_PUT)
		else $error("store began before register filled");
	store_data_a: assert property (
		(state_ff == S_PUT && busy_ff && own_ins_ff) |-> mem_we && mem_addr == yaddr_ff)
		else $error("store write misdirected");
	prio_hold_a: assert property (
		(priority_request_reg[0] && !prio_service[0]) |=> priority_request_reg[0])
		else $error("priority request dropped before service");
	drum_free_a: assert property (
		(ins_want && !busy_ff) |=> (busy_ff && own_ins_ff))
		else $error("drum transfer stalled other instructions");
	operand_fetch_a: assert property (
		(state_ff == S_FETCH && busy_ff && own_ins_ff) |-> !mem_we && mem_addr == yaddr_ff)
		else $error("parameter word not fetched from operand address");
	track_order_a: assert property (
		(eng_gnt && eng_dir_rd_ff) |-> mem_we)
		else $error("drum read did not write memory");

	sense_done_c: cover property (lacc_we);
	load_stall_c: cover property (state_ff == S_WAIT && op_ff == OP_LOAD ##3 state_ff == S_DONE);
	drum_overlap_c: cover property (eng_act_ff && op_done && !eng_go);
	prio_latch_c: cover property (prio_top_valid && !prio_now[prio_top_line]);
endmodule // io_channel_unit
`default_nettype wire

//--- verif/track_peer.sv
// Purpose: peripheral side of the drum buffer tracks
// Assumes: words to send are queued by the bench
// Notes:   mode 0 prompt, mode 1 random stalls, mode 2 sink holds off
`default_nettype none
module track_peer (
	input  wire logic        mclk,
	input  wire logic        rd_track_ready,
	output logic             rd_track_valid,
	output logic [23:0]      rd_track_data,
	input  wire logic        wr_track_valid,
	input  wire logic [23:0] wr_track_data,
	output logic             wr_track_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [23:0] src_q[$];
	logic [23:0] got_q[$];
	int          mode = 0;
	logic        sent = 1'b0;
	initial begin
		rd_track_valid = 1'b0;
		rd_track_data  = 24'h000000;
		wr_track_ready = 1'b0;
	end
	// handshakes seen at the sampling edge
	always @(posedge mclk) begin
		sent = rd_track_valid && rd_track_ready;
		if (wr_track_valid && wr_track_ready)
			got_q.push_back(wr_track_data);
	end
	// read track filled, word held until taken; released data flips
	always @(negedge mclk) begin
		if (sent)
			void'(src_q.pop_front());
		if (src_q.size() > 0 && ((rd_track_valid && !sent) || mode == 0 || $urandom_range(1))) begin
			rd_track_valid <= 1'b1;
			rd_track_data  <= src_q[0];
		end else begin
			rd_track_valid <= 1'b0;
			rd_track_data  <= ~rd_track_data;
		end
		wr_track_ready <= (mode == 0) || (mode == 1 && $urandom_range(1) == 1);
	end
endmodule // track_peer
`default_nettype wire

//--- verif/io_channel_unit_tb.sv
// Purpose: self-checking bench of the i/o channel unit
// Assumes: core memory modelled here, tracks by track_peer
// Notes:   inputs change on the falling edge of mclk
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module io_channel_unit_tb;
	import io_channel_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, nrst = 0, cmd_valid = 0, mem_gnt = 0, done_we;
	io_op_t cmd_op = OP_SENSE;
	logic [SEL_W-1:0] cmd_sel = '0, prio_top_line;
	logic [ADDR_W-1:0] cmd_addr = '0, mem_addr;
	logic [WORD_W-1:0] mem_rdata = '0, buf_fill_data = '0, lacc_data, mem_wdata, v;
	logic [WORD_W-1:0] rd_track_data, wr_track_data;
	logic [7:0] buf_fill_we = '0, buf_take = '0, prio_req_pin = '0, prio_service = '0;
	logic [7:0] buf_full, priority_request_reg, exp_m;
	logic [GROUPS-1:0][WORD_W-1:0] status_sense_lines = '0, device_select_lines, sel_exp = '0;
	logic [BUFS-1:0][WORD_W-1:0] io_buffer_register, ior_exp;
	logic [PRIO_LINES-1:0][RANK_W-1:0] prio_rank = '0;
	logic cmd_ready, op_done, lacc_we, mem_req, mem_we, prio_top_valid, drum_busy;
	logic rd_track_valid, rd_track_ready, wr_track_valid, wr_track_ready;
	logic [WORD_W-1:0] mem [0:4095];
	int bad_count = 0, check_count = 0, cyc, g, k, a, b, top, gnt_wait = 0;
	io_channel_unit io_channel_unit_inst (.mclk, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel,
		.cmd_addr, .op_done, .lacc_we, .lacc_data, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_gnt, .mem_rdata, .status_sense_lines, .device_select_lines, .buf_fill_we,
		.buf_fill_data, .buf_take, .buf_full, .io_buffer_register, .prio_req_pin, .prio_rank,
		.prio_service, .priority_request_reg, .prio_top_valid, .prio_top_line, .rd_track_valid,
		.rd_track_ready, .rd_track_data, .wr_track_valid, .wr_track_ready, .wr_track_data,
		.drum_busy);
	track_peer track_peer_inst (.mclk, .rd_track_ready, .rd_track_valid, .rd_track_data,
		.wr_track_valid, .wr_track_data, .wr_track_ready);
	always #4 mclk = ~mclk;
	// core memory: grant after 1..3 cycles, released data flips
	always @(negedge mclk) begin
		if (mem_gnt)
			mem_gnt <= 1'b0;
		else if (mem_req === 1'b1 && gnt_wait == 0) begin
			mem_gnt <= 1'b1;
			if (mem_we)
				mem[mem_addr] = mem_wdata;
			else
				mem_rdata <= mem[mem_addr];
			gnt_wait <= $urandom_range(2);
		end else if (mem_req === 1'b1)
			gnt_wait <= gnt_wait - 1;
		else
			mem_rdata <= ~mem_rdata;
	end
	function automatic logic [23:0] rnd();
		return 24'($urandom);
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// one command: offer, hold until taken, wait for the done pulse
	task automatic run_op(input io_op_t op, input int sel, input logic [11:0] adr, output int c);
		cmd_op = op;
		cmd_sel = 3'(sel);
		cmd_addr = adr;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		for (c = 0; c < 3000; c++) begin
			@(posedge mclk);
			#1;
			done_we = lacc_we;
			if (op_done === 1'b1) break;
		end
		if (c == 3000) bad_count++;
		@(negedge mclk);
	endtask
	initial begin
		repeat (30000) @(posedge mclk);
		bad_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'hD58E));
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		`CHK({cmd_ready, buf_full, priority_request_reg, device_select_lines}, {1'b1, 208'h0})
		for (g = 0; g < 8; g++) begin
			status_sense_lines[g] = (g == 7) ? 24'hFFFFFF : rnd();
			mem[12'h100 + 12'(g)] = (g == 0) ? 24'hFFFFFF : rnd();
			repeat (6) @(negedge mclk);
			run_op(OP_SENSE, g, 12'h100 + 12'(g), cyc);
			`CHK(lacc_data, status_sense_lines[g] & mem[12'h100 + 12'(g)])
			`CHK(done_we, 1'b1)
		end
		$display("sense test done");
		for (k = 0; k < 16; k++) begin
			v = (k == 8) ? 24'h000000 : rnd();
			mem[12'h200 + 12'(k)] = v;
			sel_exp[k % 8] = v;
			run_op(OP_SETUP, k % 8, 12'h200 + 12'(k), cyc);
			`CHK(device_select_lines, sel_exp)
		end
		$display("setup test done");
		for (g = 0; g < 8; g++) begin
			ior_exp[g] = rnd();
			mem[12'h300 + 12'(g)] = ior_exp[g];
			run_op(OP_LOAD, g, 12'h300 + 12'(g), cyc);
		end
		`CHK(io_buffer_register, ior_exp)
		`CHK(buf_full, 8'hFF)
		ior_exp[3] = rnd();
		mem[12'h310] = ior_exp[3];
		fork
			run_op(OP_LOAD, 3, 12'h310, cyc);
			begin
				repeat (20) @(negedge mclk);
				buf_take[3] = 1'b1;
				@(negedge mclk);
				buf_take[3] = 1'b0;
			end
		join
		`CHK(cyc >= 20, 1'b1)
		`CHK(io_buffer_register[3], ior_exp[3])
		run_op(OP_STORE, 0, 12'h400, cyc);
		`CHK(mem[12'h400], ior_exp[0])
		`CHK(buf_full[0], 1'b0)
		v = rnd();
		fork
			run_op(OP_STORE, 0, 12'h401, cyc);
			begin
				repeat (15) @(negedge mclk);
				buf_fill_data = v;
				buf_fill_we[0] = 1'b1;
				@(negedge mclk);
				buf_fill_we[0] = 1'b0;
			end
		join
		`CHK(cyc >= 15, 1'b1)
		`CHK(mem[12'h401], v)
		$display("buffer test done");
		for (k = 0; k < 4; k++) begin
			g = $urandom_range(7);
			for (a = 0; a < 8; a++) prio_rank[a] = 3'(a + g);
			a = $urandom_range(7);
			b = (a + 3) % 8;
			top = (prio_rank[a] < prio_rank[b]) ? a : b;
			exp_m = (8'h01 << a) | (8'h01 << b);
			prio_req_pin = exp_m;
			repeat (3) @(negedge mclk);
			prio_req_pin = 8'h00;
			repeat (8) @(negedge mclk);
			`CHK(priority_request_reg, exp_m)
			`CHK({prio_top_valid, prio_top_line}, {1'b1, 3'(top)})
			prio_service = 8'h01 << top;
			@(negedge mclk);
			prio_service = 8'h00;
			repeat (2) @(negedge mclk);
			`CHK(priority_request_reg, exp_m & ~(8'h01 << top))
			prio_service = exp_m;
			@(negedge mclk);
			prio_service = 8'h00;
			@(negedge mclk);
		end
		$display("priority test done");
		for (g = 0; g < 12; g++) mem[12'h500 + 12'(g)] = rnd();
		mem[12'h0F0] = {12'd12, 12'h500};
		track_peer_inst.mode = 2;
		run_op(OP_DRUM_WRITE, 0, 12'h0F0, cyc);
		`CHK(cyc < 10, 1'b1)
		run_op(OP_SENSE, 1, 12'h101, cyc);
		`CHK(lacc_data, status_sense_lines[1] & mem[12'h101])
		repeat (30) @(negedge mclk);
		`CHK({drum_busy, wr_track_valid}, 2'b11)
		track_peer_inst.mode = 1;
		for (k = 0; k < 2000 && (drum_busy || track_peer_inst.got_q.size() < 12); k++)
			@(negedge mclk);
		for (g = 0; g < 12; g++) `CHK(track_peer_inst.got_q[g], mem[12'h500 + 12'(g)])
		for (g = 0; g < 10; g++) track_peer_inst.src_q.push_back(24'hA00000 + 24'(g * 3));
		repeat (40) @(negedge mclk);
		`CHK(rd_track_ready, 1'b0)
		mem[12'h0F1] = {12'd10, 12'h600};
		run_op(OP_DRUM_READ, 0, 12'h0F1, cyc);
		for (k = 0; k < 2000 && (drum_busy || mem_req); k++)
			@(negedge mclk);
		for (g = 0; g < 10; g++) `CHK(mem[12'h600 + 12'(g)], 24'hA00000 + 24'(g * 3))
		$display("drum test done");
		conclude();
	end
endmodule // io_channel_unit_tb
`default_nettype wire
